// ==== logic/pulse_rate_meter_pkg.sv ====
// constants and types shared by the pulse rate meter core
// Functional notes
// - period timed against 20 MHz reference; frequency then calculated from it.
// - each result closes on the first input edge after a 10 ms gate, so at most one input period later.
// - auto-zero time is OFF, 0.5 s or 1 to 10 s; default 1 s.
// - no pulse for 11 s forces the reported value to zero regardless.
// - passing-time mode flags an error after 3600 s without pulses.
// - from 2 s without pulses the value steps down once a second, zero by 11 s.
// - moving average depth OFF, 2 to 128 results; OFF by default.
// - peak hold OFF, average, maximum or minimum replaces the output; default OFF.
// - section peaks gathered between start and stop are kept afterwards.
// - result accurate to 0.01 percent of shown count plus one count.
// - one active setting set plus four stored sets, any recallable.
// - a section runs once from start to stop; a new start repeats it.
package pulse_rate_meter_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ       = 10_000_000;
  localparam int REF_HZ       = 20_000_000;
  localparam int REF_PER_CLK  = REF_HZ / CLK_HZ;
  localparam int MILLI_SCALE  = 1000;
  localparam int GATE_MS      = 10;
  localparam int HALF_SEC_MS  = 500;
  localparam int FORCE_ZERO_S = 11;
  localparam int DECEL_S      = 1;
  localparam int PTIME_ERR_S  = 3600;
  localparam logic [39:0] GATE_CYC_DEF = 40'(CLK_HZ / 1000 * GATE_MS);
  localparam logic [31:0] HALF_CYC_DEF = 32'(CLK_HZ / 1000 * HALF_SEC_MS);
  localparam logic [12:0] FORCE_ZERO_HALF =
    13'(FORCE_ZERO_S * 1000 / HALF_SEC_MS);
  localparam logic [12:0] DECEL_HALF = 13'(DECEL_S * 1000 / HALF_SEC_MS);
  localparam logic [12:0] PTIME_ERR_HALF =
    13'(PTIME_ERR_S * 1000 / HALF_SEC_MS);
  localparam logic [47:0] DIVIDEND_K = 48'(REF_HZ) * 48'(MILLI_SCALE);
  localparam logic [42:0] DECEL_MUL   = 43'h0CD;
  localparam int          DECEL_SHIFT = 11;
  localparam int          PEAK_AVG_SHIFT = 3;
  // ****************************************
  // history memory
  // ****************************************
  localparam int HIST_AW    = 7;
  localparam int HIST_DEPTH = 128;
  localparam int NBANK      = 4;
  // ****************************************
  // settings
  // ****************************************
  localparam logic [3:0] AZT_OFF  = 4'h0;
  localparam logic [3:0] AZT_HALF = 4'h1;
  localparam logic [3:0] AZT_1S   = 4'h2;
  localparam logic [3:0] AZT_MAX  = 4'hB;
  localparam logic [2:0] AVG_OFF  = 3'h0;
  typedef enum logic [1:0] {
    PK_OFF = 2'h0, PK_AVG = 2'h1, PK_MAX = 2'h2, PK_MIN = 2'h3
  } peak_e;
  typedef struct packed {
    logic [3:0] azt_sel;
    logic [2:0] avg_sel;
    peak_e      peak_sel;
    logic       ptime;
  } cfg_s;
  localparam cfg_s CFG_DEFAULT = '{azt_sel: AZT_1S, avg_sel: AVG_OFF,
                                   peak_sel: PK_OFF, ptime: 1'b0};
  typedef struct packed {
    logic        store;
    logic        recall;
    logic        load;
    logic        factory;
    logic [1:0]  idx;
    cfg_s        data;
  } cfg_cmd_s;
  typedef struct packed {
    logic [31:0] val;
    logic        valid;
    logic        err;
  } meas_s;
  typedef struct packed {
    logic [31:0] max;
    logic [31:0] min;
    logic        running;
    logic        done;
  } sec_s;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [3:0] {
    ST_MEAS = 4'b0001, ST_DIV = 4'b0010, ST_HIST = 4'b0100, ST_UPD = 4'b1000
  } ph_e;
  typedef enum logic [2:0] {
    SEC_IDLE = 3'b001, SEC_RUN = 3'b010, SEC_DONE = 3'b100
  } sec_e;
endpackage

// ==== logic/rate_history_ram.sv ====
// history memory of frequency results for the moving average
`timescale 1ns/100ps
module rate_history_ram (
  // clock
  input  wire logic                                      core_clk,
  // write port
  input  wire logic                                      wr_en,
  input  wire logic [pulse_rate_meter_pkg::HIST_AW-1:0]  wr_addr,
  input  wire logic [31:0]                               wr_data,
  // read port, data one cycle after address
  input  wire logic [pulse_rate_meter_pkg::HIST_AW-1:0]  rd_addr,
  output logic      [31:0]                               rd_data
);
  import pulse_rate_meter_pkg::*;
  logic [31:0] mem [HIST_DEPTH];
  // read before write on the same address gives the old word
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // rate_history_ram

// ==== logic/pulse_rate_meter_core.sv ====
// measurement core: period timing, averaging, peak hold, zeroing, sections
`timescale 1ns/100ps
module pulse_rate_meter_core #(
  parameter logic [39:0] GATE_CYC = pulse_rate_meter_pkg::GATE_CYC_DEF,
  parameter logic [31:0] HALF_CYC = pulse_rate_meter_pkg::HALF_CYC_DEF
) (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  // conditioned pulse from the amplifier
  input  wire logic                            pulse_in,
  // settings
  input  wire pulse_rate_meter_pkg::cfg_cmd_s  cfg_cmd,
  output pulse_rate_meter_pkg::cfg_s           active_cfg,
  // section, peak hold and error control
  input  wire logic                            sec_start,
  input  wire logic                            sec_stop,
  input  wire logic                            peak_clr,
  input  wire logic                            err_clr,
  // results
  output pulse_rate_meter_pkg::meas_s          meas,
  output pulse_rate_meter_pkg::sec_s           sec
);
  import pulse_rate_meter_pkg::*;

  typedef struct packed {
    logic [2:0]  sync;
    ph_e         ph;
    logic        gate_open;
    logic [15:0] n;
    logic [39:0] cyc;
    logic [31:0] idle_cyc;
    logic [12:0] idle_half;
    logic        zeroed;
    logic [47:0] q;
    logic [40:0] rem;
    logic [39:0] dvs;
    logic [5:0]  cnt;
    logic [31:0] res;
    logic [HIST_AW-1:0] wp;
    logic [7:0]  fill;
    logic [38:0] sum;
    logic [31:0] peak;
    logic        peak_ok;
    logic [31:0] dec_step;
    sec_e        sec;
    logic        sec_any;
    logic [31:0] smax;
    logic [31:0] smin;
    cfg_s        cfg;
    cfg_s [NBANK-1:0] bank;
    logic [31:0] val;
    logic        valid;
    logic        err;
  } st_s;

  st_s s_ff;
  st_s nxt_s;
  logic [HIST_AW-1:0] ram_ra;
  logic [31:0]        ram_rd;
  logic               ram_we;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [12:0] azt_halves(input logic [3:0] sel);
    if (sel == AZT_HALF) begin
      return 13'h0001;
    end
    return 13'({sel - 4'h1, 1'b0});
  endfunction

  function automatic logic [31:0] peak_pick(input peak_e m,
                                            input logic ok,
                                            input logic [31:0] held,
                                            input logic [31:0] v);
    logic signed [32:0] d;
    d = $signed({1'b0, v}) - $signed({1'b0, held});
    if (!ok || m == PK_OFF) begin
      return v;
    end
    unique case (m)
      PK_MAX:  return (v > held) ? v : held;
      PK_MIN:  return (v < held) ? v : held;
      // smoothed average, avoids a second divider
      default: return 32'($signed({1'b0, held}) + (d >>> PEAK_AVG_SHIFT));
    endcase
  endfunction

  rate_history_ram u_hist (
    .core_clk (core_clk),
    .wr_en    (ram_we),
    .wr_addr  (s_ff.wp),
    .wr_data  (s_ff.res),
    .rd_addr  (ram_ra),
    .rd_data  (ram_rd)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic        edge_seen;
    logic        half_tick;
    logic [12:0] half_nx;
    logic [7:0]  depth;
    logic [40:0] rsh;
    logic [47:0] qn;
    logic [38:0] sum_n;
    logic [7:0]  fill_n;
    logic [31:0] avgv;
    logic [31:0] pk;
    logic        zero_now;
    edge_seen = 1'b0;
    half_tick = 1'b0;
    half_nx   = '0;
    depth     = '0;
    rsh       = '0;
    qn        = '0;
    sum_n     = '0;
    fill_n    = '0;
    avgv      = '0;
    pk        = '0;
    zero_now  = 1'b0;
    nxt_s       = s_ff;
    nxt_s.valid = 1'b0;
    ram_we      = 1'b0;
    depth  = 8'h01 << s_ff.cfg.avg_sel;
    // depth 128 wraps to the slot about to be overwritten
    ram_ra = s_ff.wp - depth[HIST_AW-1:0];

    // second flop feeds the edge detector, never the first
    nxt_s.sync = {s_ff.sync[1:0], pulse_in};
    edge_seen  = s_ff.sync[1] & ~s_ff.sync[2];

    // ****************************************
    // idle time since last edge
    // ****************************************
    half_nx = (s_ff.idle_half == '1) ? s_ff.idle_half : s_ff.idle_half + 13'h1;
    if (edge_seen) begin
      nxt_s.idle_cyc  = '0;
      nxt_s.idle_half = '0;
      nxt_s.zeroed    = 1'b0;
    end else if (s_ff.idle_cyc == HALF_CYC - 32'h1) begin
      half_tick       = 1'b1;
      nxt_s.idle_cyc  = '0;
      nxt_s.idle_half = half_nx;
    end else begin
      nxt_s.idle_cyc = s_ff.idle_cyc + 32'h1;
    end

    // ****************************************
    // gate and period capture
    // ****************************************
    nxt_s.cyc = s_ff.cyc + 40'h1;
    if (edge_seen) begin
      if (!s_ff.gate_open) begin
        nxt_s.gate_open = 1'b1;
        nxt_s.n         = '0;
        nxt_s.cyc       = '0;
      end else if (s_ff.cyc + 40'h1 >= GATE_CYC && s_ff.ph == ST_MEAS) begin
        // gate closes only on an edge, so whole periods are timed
        nxt_s.q   = DIVIDEND_K * 48'(s_ff.n + 16'h1);
        nxt_s.dvs = 40'((s_ff.cyc + 40'h1) * 40'(REF_PER_CLK));
        nxt_s.rem = '0;
        nxt_s.cnt = '0;
        nxt_s.ph  = ST_DIV;
        nxt_s.n   = '0;
        nxt_s.cyc = '0;
      end else begin
        nxt_s.n = s_ff.n + 16'h1;
      end
    end

    // ****************************************
    // divide, average, peak hold
    // ****************************************
    unique case (s_ff.ph)
      ST_MEAS: begin
      end
      ST_DIV: begin
        // millihertz resolution keeps the quotient well inside the error
        rsh = {s_ff.rem[39:0], s_ff.q[47]};
        if (rsh >= {1'b0, s_ff.dvs}) begin
          nxt_s.rem = rsh - {1'b0, s_ff.dvs};
          qn        = {s_ff.q[46:0], 1'b1};
        end else begin
          nxt_s.rem = rsh;
          qn        = {s_ff.q[46:0], 1'b0};
        end
        nxt_s.q   = qn;
        nxt_s.cnt = s_ff.cnt + 6'h1;
        if (s_ff.cnt == 6'h2F) begin
          nxt_s.res = (qn[47:32] != '0) ? '1 : qn[31:0];
          nxt_s.ph  = ST_HIST;
        end
      end
      ST_HIST: begin
        nxt_s.ph = ST_UPD;
      end
      ST_UPD: begin
        ram_we = 1'b1;
        nxt_s.wp = s_ff.wp + 7'h1;
        if (s_ff.fill >= depth) begin
          sum_n  = s_ff.sum + 39'(s_ff.res) - 39'(ram_rd);
          fill_n = s_ff.fill;
        end else begin
          sum_n  = s_ff.sum + 39'(s_ff.res);
          fill_n = s_ff.fill + 8'h1;
        end
        nxt_s.sum  = sum_n;
        nxt_s.fill = fill_n;
        if (s_ff.cfg.avg_sel != AVG_OFF && fill_n == depth) begin
          avgv = 32'(sum_n >> s_ff.cfg.avg_sel);
        end else begin
          avgv = s_ff.res;
        end
        pk = peak_pick(s_ff.cfg.peak_sel, s_ff.peak_ok, s_ff.peak, avgv);
        nxt_s.peak    = pk;
        nxt_s.peak_ok = 1'b1;
        nxt_s.val     = pk;
        nxt_s.valid   = 1'b1;
        nxt_s.ph      = ST_MEAS;
        if (s_ff.sec == SEC_RUN) begin
          nxt_s.sec_any = 1'b1;
          if (!s_ff.sec_any || avgv > s_ff.smax) begin
            nxt_s.smax = avgv;
          end
          if (!s_ff.sec_any || avgv < s_ff.smin) begin
            nxt_s.smin = avgv;
          end
        end
      end
      default: begin
        nxt_s.ph = ST_MEAS;
      end
    endcase
    if (peak_clr) begin
      nxt_s.peak_ok = 1'b0;
    end

    // ****************************************
    // rapid deceleration and auto-zero
    // ****************************************
    if (half_tick && !s_ff.zeroed) begin
      if (half_nx == DECEL_HALF) begin
        // step of about a tenth reaches zero near the forced limit
        nxt_s.dec_step =
          32'((43'(s_ff.val) * DECEL_MUL) >> DECEL_SHIFT);
      end else if (half_nx > DECEL_HALF && !half_nx[0]) begin
        nxt_s.val = (s_ff.val > s_ff.dec_step) ?
                    s_ff.val - s_ff.dec_step : '0;
        nxt_s.valid = 1'b1;
      end
    end
    zero_now = !s_ff.zeroed && !edge_seen &&
      ((s_ff.cfg.azt_sel != AZT_OFF &&
        s_ff.idle_half >= azt_halves(s_ff.cfg.azt_sel)) ||
       s_ff.idle_half >= FORCE_ZERO_HALF);
    if (zero_now) begin
      nxt_s.val       = '0;
      nxt_s.valid     = 1'b1;
      nxt_s.zeroed    = 1'b1;
      nxt_s.gate_open = 1'b0;
      nxt_s.fill      = '0;
      nxt_s.sum       = '0;
    end

    // passing-time error, a new detection beats the clear
    if (err_clr) begin
      nxt_s.err = 1'b0;
    end
    if (s_ff.cfg.ptime && s_ff.idle_half >= PTIME_ERR_HALF) begin
      nxt_s.err = 1'b1;
    end

    // ****************************************
    // section control
    // ****************************************
    unique case (s_ff.sec)
      SEC_IDLE, SEC_DONE: begin
        if (sec_start) begin
          nxt_s.sec     = SEC_RUN;
          nxt_s.sec_any = 1'b0;
          nxt_s.smax    = '0;
          nxt_s.smin    = '0;
        end
      end
      SEC_RUN: begin
        if (sec_stop) begin
          nxt_s.sec = SEC_DONE;
        end
      end
      default: begin
        nxt_s.sec = SEC_IDLE;
      end
    endcase

    // ****************************************
    // setting sets
    // ****************************************
    if (cfg_cmd.factory) begin
      nxt_s.cfg  = CFG_DEFAULT;
      nxt_s.bank = {NBANK{CFG_DEFAULT}};
    end else if (cfg_cmd.recall) begin
      nxt_s.cfg = s_ff.bank[cfg_cmd.idx];
    end else if (cfg_cmd.store) begin
      nxt_s.bank[cfg_cmd.idx] = s_ff.cfg;
    end else if (cfg_cmd.load) begin
      nxt_s.cfg = cfg_cmd.data;
      if (cfg_cmd.data.azt_sel > AZT_MAX) begin
        nxt_s.cfg.azt_sel = AZT_MAX;
      end
    end
    // a new depth or mode invalidates history and held peak
    if (cfg_cmd.factory || cfg_cmd.recall || cfg_cmd.load) begin
      nxt_s.fill    = '0;
      nxt_s.sum     = '0;
      nxt_s.peak_ok = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_ff      <= '0;
      s_ff.ph   <= ST_MEAS;
      s_ff.sec  <= SEC_IDLE;
      s_ff.cfg  <= CFG_DEFAULT;
      s_ff.bank <= {NBANK{CFG_DEFAULT}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign active_cfg  = s_ff.cfg;
  assign meas.val    = s_ff.val;
  assign meas.valid  = s_ff.valid;
  assign meas.err    = s_ff.err;
  assign sec.max     = s_ff.smax;
  assign sec.min     = s_ff.smin;
  assign sec.running = s_ff.sec[1];
  assign sec.done    = s_ff.sec[2];
endmodule // pulse_rate_meter_core

// ==== sim/pulse_source.sv ====
// model of the amplifier: square pulse train with settable half period
`timescale 1ns/100ps
module pulse_source (
  // clock
  input  wire logic        core_clk,
  // control
  input  wire logic        run,
  input  wire logic [15:0] half,
  // conditioned pulse
  output logic             pulse_in
);
  logic [15:0] cnt;
  initial begin
    pulse_in = 1'b0;
    cnt      = 16'h0;
  end
  // line rests low between trains, like a quiet amplifier
  always @(negedge core_clk) begin
    if (!run) begin
      pulse_in <= 1'b0;
      cnt      <= 16'h0;
    end else if (cnt + 16'h1 >= half) begin
      cnt      <= 16'h0;
      pulse_in <= ~pulse_in;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
endmodule // pulse_source

// ==== sim/pulse_rate_meter_asserts.sv ====
// assertion checker for the pulse rate meter core
`timescale 1ns/100ps
module pulse_rate_meter_asserts #(
  parameter logic [39:0] GATE_CYC = pulse_rate_meter_pkg::GATE_CYC_DEF,
  parameter logic [31:0] HALF_CYC = pulse_rate_meter_pkg::HALF_CYC_DEF
) (
  // clock and reset
  input wire logic                           core_clk,
  input wire logic                           rst_n,
  // inputs
  input wire logic                           pulse_in,
  input wire pulse_rate_meter_pkg::cfg_cmd_s cfg_cmd,
  input wire logic                           sec_start,
  input wire logic                           sec_stop,
  input wire logic                           peak_clr,
  input wire logic                           err_clr,
  // outputs
  input wire pulse_rate_meter_pkg::cfg_s     active_cfg,
  input wire pulse_rate_meter_pkg::meas_s    meas,
  input wire pulse_rate_meter_pkg::sec_s     sec
);
  import pulse_rate_meter_pkg::*;
  // ************************
  // idle counter
  // ************************
  logic [31:0] idle_ff;
  logic        prev_ff;
  logic        ld_only;
  assign ld_only = cfg_cmd.load && !cfg_cmd.store && !cfg_cmd.recall
                   && !cfg_cmd.factory;
  always_ff @(posedge core_clk) begin
    prev_ff <= pulse_in;
    if (!rst_n || (pulse_in && !prev_ff))
      idle_ff <= 32'h0;
    else if (idle_ff != 32'hFFFFFFFF)
      idle_ff <= idle_ff + 32'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ************************
  // properties
  // ************************
  a_reset_clears: assert property (disable iff (1'b0) !rst_n |=>
    meas.val == 32'h0 && !meas.valid && !meas.err && !sec.running)
    else $error("results not cleared by reset");
  a_reset_cfg: assert property (disable iff (1'b0) !rst_n |=>
    active_cfg == CFG_DEFAULT) else $error("settings not default");
  a_val_stands: assert property ($changed(meas.val) |-> meas.valid)
    else $error("result changed without valid");
  a_load_clamp: assert property (ld_only && cfg_cmd.data.azt_sel > AZT_MAX
    |=> active_cfg.azt_sel == AZT_MAX) else $error("zero time not clamped");
  a_load_data: assert property (ld_only && cfg_cmd.data.azt_sel <= AZT_MAX
    |=> active_cfg == $past(cfg_cmd.data)) else $error("load not taken");
  a_factory_cfg: assert property (cfg_cmd.factory |=>
    active_cfg == CFG_DEFAULT) else $error("factory load wrong");
  a_store_keeps: assert property (cfg_cmd.store && !cfg_cmd.recall
    && !cfg_cmd.factory |=> $stable(active_cfg))
    else $error("store altered settings");
  a_sec_start: assert property (sec_start && !sec.running |=>
    sec.running && !sec.done) else $error("section did not start");
  a_sec_stop: assert property (sec_stop && !sec_start && sec.running
    |=> sec.done && !sec.running) else $error("section did not stop");
  a_done_hold: assert property (sec.done && !sec_start |=>
    $stable(sec.max) && $stable(sec.min)) else $error("section peak lost");
  a_err_sticky: assert property (meas.err && !err_clr |=> meas.err)
    else $error("error flag dropped");
  // margin covers sync delay and the half-second grid
  a_force_zero: assert property (idle_ff > 23 * HALF_CYC + 32'h8
    |-> meas.val == 32'h0) else $error("value not zero when idle");
endmodule // pulse_rate_meter_asserts
bind pulse_rate_meter_core pulse_rate_meter_asserts #(
  .GATE_CYC(GATE_CYC), .HALF_CYC(HALF_CYC)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .pulse_in(pulse_in),
  .cfg_cmd(cfg_cmd), .sec_start(sec_start), .sec_stop(sec_stop),
  .peak_clr(peak_clr), .err_clr(err_clr), .active_cfg(active_cfg),
  .meas(meas), .sec(sec));

// ==== sim/tb_top.sv ====
// self-checking bench for the pulse rate meter core
`timescale 1ns/100ps
module tb_top;
  import pulse_rate_meter_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        pulse_in;
  logic        sec_start;
  logic        sec_stop;
  logic        peak_clr;
  logic        err_clr;
  logic        run;
  logic [15:0] half;
  cfg_cmd_s    cfg_cmd;
  cfg_s        active_cfg;
  cfg_s        c;
  meas_s       meas;
  sec_s        sec;
  logic [31:0] v0;
  int          mismatches = 0;
  int          comparisons = 0;
  always #50 core_clk = ~core_clk;
  // short counts keep the run brief
  pulse_rate_meter_core #(.GATE_CYC(40'hC8), .HALF_CYC(32'h64)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .pulse_in(pulse_in),
    .cfg_cmd(cfg_cmd), .active_cfg(active_cfg), .sec_start(sec_start),
    .sec_stop(sec_stop), .peak_clr(peak_clr), .err_clr(err_clr),
    .meas(meas), .sec(sec));
  pulse_source i_src (.core_clk(core_clk), .run(run), .half(half),
    .pulse_in(pulse_in));
  // ************************
  // tasks
  // ************************
  task print_verdict;
    $display("counts: %0d compared, %0d wrong", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_cfg(string n, cfg_s e, cfg_s g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // tolerance of 0.01 percent plus one count
  task chk_val(string n, logic [31:0] e, logic [31:0] g);
    logic ok;
    ok = (g >= e - e / 10000 - 1) && (g <= e + e / 10000 + 1);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task cmd(logic [3:0] k, logic [1:0] idx, cfg_s d);
    @(negedge core_clk);
    cfg_cmd = cfg_cmd_s'({k, idx, d});
    @(negedge core_clk);
    cfg_cmd = '0;
    @(negedge core_clk);
  endtask
  task sec_pulse(logic stop);
    @(negedge core_clk);
    sec_start = !stop;
    sec_stop  = stop;
    @(negedge core_clk);
    sec_start = 1'b0;
    sec_stop  = 1'b0;
  endtask
  task wait_res(int bound, logic zero);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < bound && !hit; i++) begin
      @(posedge core_clk);
      #1;
      hit = (meas.valid === 1'b1) && (!zero || meas.val === 32'h0);
    end
    if (!hit) begin
      mismatches++;
      $display("wrong value result exp 1 got 0");
      print_verdict;
    end
  endtask
  // ************************
  // sequence
  // ************************
  initial begin
    rst_n = 1'b0;
    cfg_cmd = '0;
    sec_start = 1'b0;
    sec_stop = 1'b0;
    peak_clr = 1'b0;
    err_clr = 1'b0;
    run = 1'b0;
    half = 16'h14;
    repeat (5) @(negedge core_clk);
    chk_cfg("reset cfg", CFG_DEFAULT, active_cfg);
    chk("reset val", 32'h0, meas.val);
    rst_n = 1'b1;
    $display("test reset done");
    c = cfg_s'{4'hF, 3'h2, PK_MAX, 1'b0};
    cmd(4'h2, 2'h0, c);
    c.azt_sel = AZT_MAX;
    chk_cfg("clamp", c, active_cfg);
    cmd(4'h8, 2'h2, c);
    cmd(4'h2, 2'h0, cfg_s'{AZT_HALF, AVG_OFF, PK_MIN, 1'b1});
    chk_cfg("load", cfg_s'{AZT_HALF, AVG_OFF, PK_MIN, 1'b1}, active_cfg);
    cmd(4'h4, 2'h2, '0);
    chk_cfg("recall", c, active_cfg);
    cmd(4'h1, 2'h0, '0);
    chk_cfg("factory", CFG_DEFAULT, active_cfg);
    cmd(4'h4, 2'h2, '0);
    chk_cfg("bank reset", CFG_DEFAULT, active_cfg);
    for (int k = 0; k < 8; k++) begin
      c = cfg_s'{4'(k + 3), 3'(k), peak_e'(k[1:0]), k[0]};
      cmd(4'h2, 2'h0, c);
      chk_cfg("modes", c, active_cfg);
    end
    $display("test settings done");
    cmd(4'h1, 2'h0, '0);
    sec_pulse(1'b0);
    run <= 1'b1;
    wait_res(600, 1'b0);
    wait_res(600, 1'b0);
    chk_val("rate fast", 32'h0EE6B280, meas.val);
    chk("running", 32'h1, 32'(sec.running));
    chk_val("sec max", 32'h0EE6B280, sec.max);
    sec_pulse(1'b1);
    chk("done", 32'h1, 32'(sec.done));
    half <= 16'h28;
    wait_res(600, 1'b0);
    wait_res(600, 1'b0);
    chk_val("rate slow", 32'h07735940, meas.val);
    chk("sec kept", 32'h0EE6B280, sec.max);
    chk("sec min", 32'h0EE6B280, sec.min);
    sec_pulse(1'b0);
    chk("restart", 32'h2, 32'({sec.running, sec.done}));
    $display("test measure done");
    // depth two; first result after a rate change is a mixed gate
    half <= 16'h14;
    cmd(4'h2, 2'h0, cfg_s'{AZT_1S, 3'h1, PK_MAX, 1'b0});
    repeat (3) wait_res(600, 1'b0);
    chk_val("avg fast", 32'h0EE6B280, meas.val);
    half <= 16'h28;
    repeat (3) wait_res(600, 1'b0);
    chk_val("peak max", 32'h0EE6B280, meas.val);
    @(negedge core_clk);
    peak_clr = 1'b1;
    @(negedge core_clk);
    peak_clr = 1'b0;
    repeat (2) wait_res(600, 1'b0);
    chk_val("peak clear", 32'h07735940, meas.val);
    $display("test peak done");
    cmd(4'h2, 2'h0, cfg_s'{AZT_HALF, AVG_OFF, PK_OFF, 1'b0});
    wait_res(600, 1'b0);
    run <= 1'b0;
    wait_res(300, 1'b1);
    chk("auto zero", 32'h0, meas.val);
    $display("test auto zero done");
    cmd(4'h2, 2'h0, cfg_s'{AZT_OFF, AVG_OFF, PK_OFF, 1'b0});
    run <= 1'b1;
    wait_res(600, 1'b0);
    wait_res(600, 1'b0);
    v0 = meas.val;
    run <= 1'b0;
    // first decay step lands two seconds after the last edge
    repeat (300) @(posedge core_clk);
    wait_res(500, 1'b0);
    chk("decay", 32'h1, 32'(meas.val < v0 && meas.val != 32'h0));
    wait_res(2600, 1'b1);
    chk("forced zero", 32'h0, meas.val);
    chk("no error", 32'h0, 32'(meas.err));
    $display("test decay done");
    print_verdict;
  end
endmodule // tb_top
